/* cdx_pkg.sv */
/*
 * Package for the clear, decrement, increment, skip and branch execution
 * block: operation codes, operand widths, reset values and carriers.
 * Assumes a single core clock and an active high asynchronous reset.
 */
package cdx_pkg;

   localparam int CDX_DATA_W = 8;
   localparam int CDX_ADDR_W = 7;
   localparam int CDX_PC_W = 13;
   localparam int CDX_LIT_W = 11;
   localparam int CDX_LATCH_W = 8;

   localparam logic [7:0] CDX_ZERO = 8'h00;
   localparam logic [7:0] CDX_ONE = 8'h01;
   localparam logic [7:0] CDX_W_RST = 8'h00;
   localparam logic [12:0] CDX_PC_RST = 13'h0000;
   localparam logic CDX_Z_RST = 1'b0;

   // Field positions inside the high latch and the program counter.
   localparam int CDX_LATCH_HI = 4;
   localparam int CDX_LATCH_LO = 3;
   localparam int CDX_PC_LIT_HI = 10;

   // Destination select values.
   localparam logic CDX_DEST_W = 1'b0;
   localparam logic CDX_DEST_F = 1'b1;

   // Cycles that a skip or a branch stalls, beyond the issue cycle.
   localparam logic [1:0] CDX_FLUSH_CYCLES = 2'h1;

   typedef enum logic [2:0] {
      CDX_OP_NONE,
      CDX_OP_CLEAR_FILE,
      CDX_OP_CLEAR_WORK,
      CDX_OP_DECREMENT,
      CDX_OP_DECREMENT_SKIP_ZERO,
      CDX_OP_INCREMENT_SKIP_ZERO,
      CDX_OP_JUMP
   } cdx_op_t;

   typedef struct packed {
      cdx_op_t op;
      logic [CDX_ADDR_W-1:0] addr;
      logic dest;
      logic [CDX_LIT_W-1:0] lit;
   } cdx_instr_t;

   typedef struct packed {
      logic wr;
      logic [CDX_ADDR_W-1:0] addr;
      logic [CDX_DATA_W-1:0] data;
   } cdx_fwrite_t;

endpackage

/* cdx_alu.sv */
/*
 * Arithmetic unit of the execution block: forms the 8-bit result of a
 * clear, decrement or increment and its zero indication.
 * Assumes the operand is already read from the file register.
 */
`timescale 1ns/1ps
module cdx_alu
   import cdx_pkg::*;
(
   // Operation and operand.
   input cdx_pkg::cdx_op_t op,
   input wire logic [cdx_pkg::CDX_DATA_W-1:0] operand,
   // Result.
   output logic [cdx_pkg::CDX_DATA_W-1:0] result,
   output logic is_zero
);

   wire logic do_dec;
   wire logic do_inc;

   assign do_dec = (op == CDX_OP_DECREMENT)
      || (op == CDX_OP_DECREMENT_SKIP_ZERO);
   assign do_inc = (op == CDX_OP_INCREMENT_SKIP_ZERO);

   // Arithmetic wraps modulo 256.
   assign result = do_dec ? operand - CDX_ONE :
      do_inc ? operand + CDX_ONE : CDX_ZERO;
   assign is_zero = (result == CDX_ZERO);

endmodule

/* cdx_exec.sv */
/*
 * Execution block for clear file, clear work, decrement, decrement and
 * skip if zero, increment and skip if zero, and unconditional jump.
 * Assumes the fetch stage presents one decoded instruction with a valid
 * strobe, reads the addressed file register combinationally onto
 * file_rdata, and honours flush by issuing no instruction while it is high.
 */
// Operation
// - Clear file: write zero, set zero flag.
// - File address 0..127, destination bit 0/1.
// - Decrement to W or file, update zero.
// - Clear work: W gets zero, set zero.
// - Decrement skip: flags unchanged, zero skips next.
// - Increment skip: flags unchanged, zero skips next.
// - Jump copies latch bits 4:3 to PC[12:11].
// - Jump takes two cycles, flags untouched.
`timescale 1ns/1ps
module cdx_exec
   import cdx_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Instruction issue.
   input wire logic instr_valid,
   input cdx_pkg::cdx_instr_t instr,
   input wire logic [cdx_pkg::CDX_LATCH_W-1:0] pc_high_latch,
   // File register read port.
   output logic [cdx_pkg::CDX_ADDR_W-1:0] file_raddr,
   input wire logic [cdx_pkg::CDX_DATA_W-1:0] file_rdata,
   // File register write port.
   output cdx_pkg::cdx_fwrite_t file_write,
   // Architectural state.
   output logic [cdx_pkg::CDX_DATA_W-1:0] work_q,
   output logic zero_flag_q,
   output logic [cdx_pkg::CDX_PC_W-1:0] pc_q,
   output logic pc_load_q,
   // Pipeline control.
   output logic flush,
   output logic busy
);
   import cdx_pkg::*;

   logic [CDX_DATA_W-1:0] work_d;
   logic zero_flag_d;
   logic [CDX_PC_W-1:0] pc_d;
   logic pc_load_d;
   logic [1:0] stall_q;
   logic [1:0] stall_d;
   cdx_fwrite_t fwr_q;
   cdx_fwrite_t fwr_d;

   wire logic issue;
   wire cdx_op_t op;
   wire logic [CDX_DATA_W-1:0] alu_result;
   wire logic alu_zero;
   wire logic is_clear_file;
   wire logic is_clear_work;
   wire logic is_dec;
   wire logic is_skip;
   wire logic is_jump;
   wire logic to_file;
   wire logic to_work;
   wire logic take_skip;
   wire logic [CDX_PC_W-1:0] jump_target;

   // Instructions issued while a slot is being flushed are discarded.
   assign issue = instr_valid && (stall_q == 2'h0);
   assign op = issue ? instr.op : CDX_OP_NONE;
   assign file_raddr = instr.addr;

   cdx_alu u_alu (
      .op(op),
      .operand(file_rdata),
      .result(alu_result),
      .is_zero(alu_zero)
   );

   assign is_clear_file = (op == CDX_OP_CLEAR_FILE);
   assign is_clear_work = (op == CDX_OP_CLEAR_WORK);
   assign is_dec = (op == CDX_OP_DECREMENT);
   assign is_skip = (op == CDX_OP_DECREMENT_SKIP_ZERO)
      || (op == CDX_OP_INCREMENT_SKIP_ZERO);
   assign is_jump = (op == CDX_OP_JUMP);

   // Destination select picks W on 0 and the file register on 1.
   assign to_file = is_clear_file
      || ((is_dec || is_skip) && (instr.dest == CDX_DEST_F));
   assign to_work = is_clear_work
      || ((is_dec || is_skip) && (instr.dest == CDX_DEST_W));

   assign take_skip = is_skip && alu_zero;

   assign jump_target = {
      pc_high_latch[CDX_LATCH_HI:CDX_LATCH_LO],
      instr.lit[CDX_PC_LIT_HI:0]
   };

   assign work_d = to_work ? alu_result : work_q;

   // Only clears and plain decrement touch the zero flag.
   assign zero_flag_d = (is_clear_file || is_clear_work) ? 1'b1 :
      is_dec ? alu_zero : zero_flag_q;

   assign pc_d = is_jump ? jump_target : pc_q;
   assign pc_load_d = is_jump;

   assign fwr_d.wr = to_file;
   assign fwr_d.addr = instr.addr;
   assign fwr_d.data = alu_result;

   // A taken skip or a jump turns the following slot into a no-operation.
   assign stall_d = (take_skip || is_jump) ? CDX_FLUSH_CYCLES :
      (stall_q != 2'h0) ? stall_q - 2'h1 : 2'h0;

   assign flush = take_skip || is_jump || (stall_q != 2'h0);
   assign busy = (stall_q != 2'h0);
   assign file_write = fwr_q;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         work_q <= CDX_W_RST;
         zero_flag_q <= CDX_Z_RST;
         pc_q <= CDX_PC_RST;
         pc_load_q <= 1'b0;
         stall_q <= 2'h0;
         fwr_q <= '0;
      end else begin
         work_q <= work_d;
         zero_flag_q <= zero_flag_d;
         pc_q <= pc_d;
         pc_load_q <= pc_load_d;
         stall_q <= stall_d;
         fwr_q <= fwr_d;
      end
   end

endmodule

/* cdx_exec_asserts.sv */
/* Checker on the ports of the execution block.
   Assumes it is bound to every instance of cdx_exec. */
`timescale 1ns/1ps
module cdx_exec_chk
   import cdx_pkg::*;
(
   // Ports of the block.
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic instr_valid,
   input cdx_pkg::cdx_instr_t instr,
   input wire logic [7:0] pc_high_latch,
   input wire logic [7:0] file_rdata,
   input cdx_pkg::cdx_fwrite_t file_write,
   input wire logic [7:0] work_q,
   input wire logic zero_flag_q,
   input wire logic [12:0] pc_q,
   input wire logic pc_load_q,
   input wire logic flush,
   input wire logic busy
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   wire [2:0] op = instr_valid && !busy ? instr.op : 3'h0;
   sequence s_skip; flush ##1 busy ##1 !busy; endsequence
   sequence s_hold; ##1 $stable(zero_flag_q); endsequence
   property p_clr_f; op == CDX_OP_CLEAR_FILE |=>
      file_write == {1'b1, $past(instr.addr), 8'h00} && zero_flag_q; endproperty
   a_clr_f: assert property (p_clr_f) else $error("clear file");
   property p_clr_w; op == CDX_OP_CLEAR_WORK |=>
      work_q == 8'h00 && zero_flag_q; endproperty
   a_clr_w: assert property (p_clr_w) else $error("clear work");
   property p_dec_w; op == CDX_OP_DECREMENT && !instr.dest |=> work_q ==
      $past(file_rdata) - 8'h01 && zero_flag_q == (work_q == 8'h00); endproperty
   a_dec_w: assert property (p_dec_w) else $error("dec to w");
   property p_dec_f; op == CDX_OP_DECREMENT && instr.dest |=> file_write ==
      {1'b1, $past(instr.addr), $past(file_rdata) - 8'h01}; endproperty
   a_dec_f: assert property (p_dec_f) else $error("dec to file");
   property p_dsz; op == CDX_OP_DECREMENT_SKIP_ZERO && file_rdata == 8'h01
      |-> s_skip and s_hold; endproperty
   a_dsz: assert property (p_dsz) else $error("dec skip");
   property p_isz; op == CDX_OP_INCREMENT_SKIP_ZERO && file_rdata == 8'hFF
      |-> s_skip and s_hold; endproperty
   a_isz: assert property (p_isz) else $error("inc skip");
   property p_jmp; op == CDX_OP_JUMP |=> pc_load_q &&
      pc_q == {$past(pc_high_latch[4:3]), $past(instr.lit)}; endproperty
   a_jmp: assert property (p_jmp) else $error("jump target");
   property p_jmp_t; op == CDX_OP_JUMP |-> s_skip and s_hold; endproperty
   a_jmp_t: assert property (p_jmp_t) else $error("jump cycles");
endmodule
bind cdx_exec cdx_exec_chk chk (.clk_sys, .reset, .instr_valid, .instr,
   .pc_high_latch, .file_rdata, .file_write, .work_q, .zero_flag_q, .pc_q,
   .pc_load_q, .flush, .busy);

/* tb_top.sv */
/* Random instruction bench for the execution block with a file store.
   Assumes the package and the checker are compiled first. */
`timescale 1ns/1ps
module tb_top;
   import cdx_pkg::*;
   logic clk_sys, reset, instr_valid, zero_flag_q, pc_load_q, flush, busy;
   logic z, sk;
   cdx_instr_t instr;
   cdx_fwrite_t file_write;
   logic [7:0] pc_high_latch, work_q, w, r, mem [128];
   logic [6:0] file_raddr;
   logic [12:0] pc_q, pc;
   logic [15:0] fw;
   logic [39:0] notes [$];
   int n_errors = 0, n_tests = 0, seed = 32'hE574, i;
   wire [39:0] obs = {{16{file_write.wr}} & file_write, work_q, zero_flag_q,
      pc_load_q, pc_q, busy};
   cdx_exec dut (.clk_sys(clk_sys), .reset(reset), .instr_valid(instr_valid),
      .instr(instr), .pc_high_latch(pc_high_latch), .file_raddr(file_raddr),
      .file_rdata(mem[file_raddr]), .file_write(file_write), .work_q(work_q),
      .zero_flag_q(zero_flag_q), .pc_q(pc_q), .pc_load_q(pc_load_q),
      .flush(flush), .busy(busy));
   task automatic check(logic [39:0] seen, logic [39:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t %h %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      clk_sys = 0;
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (9999) @(posedge clk_sys);
      n_errors++;
      print_verdict;
   end
   always @(posedge clk_sys) begin
      #1;
      if (notes.size() > 0)
         check(obs, notes.pop_front());
   end
   initial begin
      {reset, instr_valid, instr, pc_high_latch, w, z, pc} = 54'h20000000000000;
      for (i = 0; i < 128; i++) mem[i] = 8'($random(seed));
      repeat (2) @(posedge clk_sys);
      #2 reset = 0;
      repeat (300) begin
         {instr.addr, instr.dest, instr.lit} = 19'($random(seed));
         instr.op = cdx_op_t'(3'($unsigned($random(seed)) % 7));
         pc_high_latch = 8'($random(seed));
         instr_valid = 1;
         if (seed[1])
            mem[instr.addr] = (instr.op == CDX_OP_INCREMENT_SKIP_ZERO) ?
               8'hFF : 8'h01;
         r = mem[instr.addr] +
            ((instr.op == CDX_OP_INCREMENT_SKIP_ZERO) ? 8'h01 : 8'hFF);
         sk = instr.op > CDX_OP_DECREMENT && (r == 0 || instr.op[1]);
         fw = 0;
         case (instr.op)
            CDX_OP_NONE: ;
            CDX_OP_CLEAR_FILE: {fw, z} = {1'b1, instr.addr, 8'h00, 1'b1};
            CDX_OP_CLEAR_WORK: {w, z} = 9'h001;
            CDX_OP_JUMP: pc = {pc_high_latch[4:3], instr.lit};
            default: begin
               if (instr.dest) fw = {1'b1, instr.addr, r};
               else w = r;
               if (instr.op == CDX_OP_DECREMENT) z = r == 0;
            end
         endcase
         notes.push_back({fw, w, z, instr.op == CDX_OP_JUMP, pc, sk});
         #1 check({32'h0, file_raddr, flush}, {32'h0, instr.addr, sk});
         @(posedge clk_sys) #2;
         if (fw[15]) mem[instr.addr] = fw[7:0];
         if (sk) begin
            instr.op = CDX_OP_CLEAR_FILE;
            notes.push_back({16'h0000, w, z, 1'b0, pc, 1'b0});
            #1 check({39'h0, flush}, {39'h0, 1'b1});
            @(posedge clk_sys) #2;
         end
      end
      instr_valid = 0;
      repeat (2) @(posedge clk_sys);
      print_verdict;
   end
endmodule
